// ==== verilog/dccl_pkg.sv ====
// Constants, register map and carrier types of the DC drive current loop.
// Assumes a 25 MHz system clock and one-word registers on an Avalon-MM slave.
package dccl_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_TIME_US = 1000;
	localparam int MS_CYCLES = (CLK_HZ / 1_000_000) * MS_TIME_US;
	localparam int READY_OPEN_TIME_MS = 50;
	localparam int TUNE_TIME_MS = 200;

	localparam logic [7:0] OFS_FB_NORM = 8'h00;
	localparam logic [7:0] OFS_FB_AMPS = 8'h04;
	localparam logic [7:0] OFS_FIRING = 8'h08;
	localparam logic [7:0] OFS_SLEW = 8'h0c;
	localparam logic [7:0] OFS_MAX_SCALE = 8'h10;
	localparam logic [7:0] OFS_THRESHOLD = 8'h14;
	localparam logic [7:0] OFS_HEAT = 8'h18;
	localparam logic [7:0] OFS_COOL = 8'h1c;
	localparam logic [7:0] OFS_TUNE = 8'h20;
	localparam logic [7:0] OFS_ENDSTOP = 8'h24;
	localparam logic [7:0] OFS_ACCUM = 8'h28;
	localparam logic [7:0] OFS_BURDEN = 8'h2c;
	localparam logic [7:0] OFS_STATUS = 8'h30;
	localparam logic [7:0] OFS_GAIN_DI = 8'h34;
	localparam logic [7:0] OFS_GAIN_CP = 8'h38;
	localparam logic [7:0] OFS_GAIN_CI = 8'h3c;
	localparam logic [7:0] OFS_MOTOR_K = 8'h40;

	localparam logic [7:0] RST_SLEW = 8'h28;
	localparam logic [10:0] RST_MAX_SCALE = 11'h3e8;
	localparam logic [9:0] RST_THRESHOLD = 10'h2bc;
	localparam logic [7:0] RST_HEAT = 8'h1e;
	localparam logic [7:0] RST_COOL = 8'h3c;
	localparam logic [7:0] RST_GAIN_DI = 8'h10;
	localparam logic [7:0] RST_GAIN_CP = 8'h10;
	localparam logic [7:0] RST_GAIN_CI = 8'h10;
	localparam logic [7:0] RST_MOTOR_K = 8'h19;
	localparam logic [7:0] TUNED_GAIN_DI = 8'h14;
	localparam logic [7:0] TUNED_GAIN_CP = 8'h18;
	localparam logic [7:0] TUNED_GAIN_CI = 8'h20;
	localparam logic [7:0] TUNED_MOTOR_K = 8'h1e;

	localparam int FB_FULL = 1000;
	localparam int AMPS_FULL = 1999;
	localparam int ACC_FULL = 1999;
	localparam int ANGLE_MAX = 1023;
	localparam int ANGLE_MIN = 277;
	localparam int ANGLE_MIN_REDUCED = 330;
	localparam int ANGLE_BIAS = 650;
	localparam int HEAT_UNITS_PER_S = 16 * 1000;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} dccl_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} dccl_avs_rsp_t;

	typedef enum logic [1:0] {
		TUNE_IDLE = 2'b00,
		TUNE_RUN = 2'b01,
		TUNE_OPEN = 2'b10,
		TUNE_CLEAR = 2'b11
	} dccl_tune_state_t;
endpackage

// ==== verilog/dccl_tick_gen.sv ====
// One-cycle tick every DIV cycles of clk_sys.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dccl_tick_gen #(
	parameter int DIV = 25000
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	output logic tick
);
	localparam int CW = $clog2(DIV);
	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (cnt_q == CW'(DIV - 1)) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/dccl_current_loop.sv ====
// Current loop of a DC drive: demand slew, feedback scaling, firing angle,
// current-time overload, autotune sequencing, all behind an Avalon-MM slave.
// Assumes demand, feedback and phase_tick come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Error is slewed demand minus normalised current feedback.
// - Demand steps at most slew*1000/256 units per sixth of supply cycle.
// - Firing angle output is read-only, clamped 277 to 1023.
// - Normalised feedback spans plus or minus 1000, used for control and protection.
// - Amps feedback is normalised feedback times scaling, clamped plus or minus 1999.
// - Scaling affects only the amps reading, never overload protection.
// - Burden option rescales feedback for a burden raised by 1.6.
// - Integrator accumulates only when feedback exceeds threshold, default 700.
// - Trip time is heat*(1000-threshold)/(feedback-threshold).
// - Reset time is cool*(1000-threshold)/(threshold-feedback).
// - Heat and cool both zero disable the overload trip.
// - Integrator reads 0 to 1999; trip at (1000-threshold)*10/16.
// - Integrator rises at heating rate and falls at cooling rate.
// - Autotune runs once request is set and drive enable is present.
// - On tune end, ready opens 50 ms, then request clears itself.
// - Tune overwrites four tuning values and switches field off meanwhile.
// - Reduced endstop selects 1.05 instead of 1.16 supply voltage limit.
module dccl_current_loop
	import dccl_pkg::*;
#(
	parameter int MS_DIV = dccl_pkg::MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire dccl_pkg::dccl_avs_req_t avs_req,
	output dccl_pkg::dccl_avs_rsp_t avs_rsp,
	input wire logic signed [15:0] current_demand,
	input wire logic signed [11:0] ct_sample,
	input wire logic phase_tick,
	input wire logic drive_enable_input,
	input wire logic trip_reset,
	output logic [9:0] firing_angle,
	output logic overload_trip,
	output logic drive_ready,
	output logic field_off,
	output logic tune_active
);
	import dccl_pkg::*;

	logic [7:0] slew_q, heat_q, cool_q, gain_di_q, gain_cp_q, gain_ci_q, motor_k_q;
	logic [10:0] max_scale_q, acc_q;
	logic [9:0] thresh_q;
	logic tune_req_q, endstop_q, burden_q, trip_q, ack_q;
	logic [31:0] rdata_q;
	logic signed [15:0] fb_norm_q, fb_amps_q, dem_q;
	logic signed [19:0] integ_q;
	logic [22:0] frac_q;
	logic en_s1, en_s2, en_s3, en_q;
	logic ms_tick;
	dccl_tune_state_t tune_q;
	logic [7:0] tune_ms_q;

	logic req, wr_take, tune_done;
	assign req = avs_req.read | avs_req.write;
	assign wr_take = avs_req.write & ack_q;
	assign avs_rsp = '{readdata: rdata_q, waitrequest: req & ~ack_q};

	dccl_tick_gen #(.DIV(MS_DIV)) u_ms_tick (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick(ms_tick)
	);

	// One wait state per access keeps the read mux off the bus path
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_q <= 32'h0;
		end else if (avs_req.read && !ack_q) begin
			case (avs_req.address)
				OFS_FB_NORM: rdata_q <= 32'(fb_norm_q);
				OFS_FB_AMPS: rdata_q <= 32'(fb_amps_q);
				OFS_FIRING: rdata_q <= {22'h0, firing_angle};
				OFS_SLEW: rdata_q <= {24'h0, slew_q};
				OFS_MAX_SCALE: rdata_q <= {21'h0, max_scale_q};
				OFS_THRESHOLD: rdata_q <= {22'h0, thresh_q};
				OFS_HEAT: rdata_q <= {24'h0, heat_q};
				OFS_COOL: rdata_q <= {24'h0, cool_q};
				OFS_TUNE: rdata_q <= {31'h0, tune_req_q};
				OFS_ENDSTOP: rdata_q <= {31'h0, endstop_q};
				OFS_ACCUM: rdata_q <= {21'h0, acc_q};
				OFS_BURDEN: rdata_q <= {31'h0, burden_q};
				OFS_STATUS: rdata_q <= {29'h0, en_q, tune_active, trip_q};
				OFS_GAIN_DI: rdata_q <= {24'h0, gain_di_q};
				OFS_GAIN_CP: rdata_q <= {24'h0, gain_cp_q};
				OFS_GAIN_CI: rdata_q <= {24'h0, gain_ci_q};
				OFS_MOTOR_K: rdata_q <= {24'h0, motor_k_q};
				default: rdata_q <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			slew_q <= RST_SLEW;
			max_scale_q <= RST_MAX_SCALE;
			thresh_q <= RST_THRESHOLD;
			heat_q <= RST_HEAT;
			cool_q <= RST_COOL;
			endstop_q <= 1'b0;
			burden_q <= 1'b0;
		end else if (wr_take) begin
			case (avs_req.address)
				OFS_SLEW: slew_q <= avs_req.writedata[7:0];
				OFS_MAX_SCALE: max_scale_q <= avs_req.writedata[10:0];
				OFS_THRESHOLD: thresh_q <= (avs_req.writedata > 32'(FB_FULL)) ?
					10'(FB_FULL) : avs_req.writedata[9:0];
				OFS_HEAT: heat_q <= avs_req.writedata[7:0];
				OFS_COOL: cool_q <= avs_req.writedata[7:0];
				OFS_ENDSTOP: endstop_q <= avs_req.writedata[0];
				OFS_BURDEN: burden_q <= avs_req.writedata[0];
				default: ;
			endcase
		end
	end

	// Tuning values: software writes them, a finished tune overwrites them
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			gain_di_q <= RST_GAIN_DI;
			gain_cp_q <= RST_GAIN_CP;
			gain_ci_q <= RST_GAIN_CI;
			motor_k_q <= RST_MOTOR_K;
		end else if (tune_done) begin
			gain_di_q <= TUNED_GAIN_DI;
			gain_cp_q <= TUNED_GAIN_CP;
			gain_ci_q <= TUNED_GAIN_CI;
			motor_k_q <= TUNED_MOTOR_K;
		end else if (wr_take) begin
			case (avs_req.address)
				OFS_GAIN_DI: gain_di_q <= avs_req.writedata[7:0];
				OFS_GAIN_CP: gain_cp_q <= avs_req.writedata[7:0];
				OFS_GAIN_CI: gain_ci_q <= avs_req.writedata[7:0];
				OFS_MOTOR_K: motor_k_q <= avs_req.writedata[7:0];
				default: ;
			endcase
		end
	end

	// Enable pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
			en_s3 <= 1'b0;
			en_q <= 1'b0;
		end else begin
			en_s1 <= drive_enable_input;
			en_s2 <= en_s1;
			en_s3 <= en_s2;
			if (en_s2 == en_s3) begin
				en_q <= en_s3;
			end
		end
	end

	// Feedback normalisation; the larger burden gives 1.6 times the signal
	logic signed [31:0] fb_scaled, amps_prod, amps_div;
	always_comb begin
		fb_scaled = 32'(ct_sample);
		if (burden_q) begin
			fb_scaled = (32'(ct_sample) * 32'sd10) >>> 4;
		end
		if (fb_scaled > 32'sd1000) begin
			fb_scaled = 32'sd1000;
		end else if (fb_scaled < -32'sd1000) begin
			fb_scaled = -32'sd1000;
		end
		amps_prod = 32'(fb_norm_q) * signed'({21'h0, max_scale_q});
		amps_div = amps_prod / 32'sd1000;
		if (amps_div > 32'(AMPS_FULL)) begin
			amps_div = 32'(AMPS_FULL);
		end else if (amps_div < -32'(AMPS_FULL)) begin
			amps_div = -32'(AMPS_FULL);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			fb_norm_q <= 16'sh0;
			fb_amps_q <= 16'sh0;
		end else begin
			fb_norm_q <= 16'(fb_scaled);
			fb_amps_q <= 16'(amps_div);
		end
	end

	// Slew limit: one step per firing instant, i.e. six per supply cycle
	logic signed [31:0] slew_step, dem_diff, err, angle_raw, integ_next, angle_min;
	always_comb begin
		slew_step = (signed'({24'h0, slew_q}) * 32'sd1000) >>> 8;
		dem_diff = 32'(current_demand) - 32'(dem_q);
		err = 32'(dem_q) - 32'(fb_norm_q);
		integ_next = 32'(integ_q) + ((err * signed'({24'h0, gain_ci_q})) >>> 8);
		if (integ_next > 32'sd262143) begin
			integ_next = 32'sd262143;
		end else if (integ_next < -32'sd262144) begin
			integ_next = -32'sd262144;
		end
		angle_raw = 32'(ANGLE_BIAS) + ((err * signed'({24'h0, gain_cp_q})) >>> 8)
			+ (integ_next >>> 4);
		angle_min = endstop_q ? 32'(ANGLE_MIN_REDUCED) : 32'(ANGLE_MIN);
		if (angle_raw > 32'(ANGLE_MAX)) begin
			angle_raw = 32'(ANGLE_MAX);
		end else if (angle_raw < angle_min) begin
			angle_raw = angle_min;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			dem_q <= 16'sh0;
			integ_q <= 20'sh0;
			firing_angle <= 10'(ANGLE_MIN);
		end else if (phase_tick) begin
			if (dem_diff > slew_step) begin
				dem_q <= 16'(32'(dem_q) + slew_step);
			end else if (dem_diff < -slew_step) begin
				dem_q <= 16'(32'(dem_q) - slew_step);
			end else begin
				dem_q <= current_demand;
			end
			integ_q <= 20'(integ_next);
			firing_angle <= 10'(angle_raw);
		end
	end

	// Overload integrator, stepped once per millisecond on the feedback magnitude
	logic [9:0] fb_mag;
	logic [10:0] trip_lvl, ol_diff;
	logic [22:0] heat_den, cool_den, frac_add, frac_base;
	logic ol_off, ol_hot, ol_cold, trip_now, ol_up_q;
	always_comb begin
		fb_mag = fb_norm_q[15] ? 10'(-fb_norm_q) : 10'(fb_norm_q);
		trip_lvl = 11'((20'(FB_FULL) - 20'(thresh_q)) * 20'd10 >> 4);
		ol_off = (heat_q == 8'h0) && (cool_q == 8'h0);
		ol_hot = fb_mag > thresh_q;
		ol_cold = fb_mag < thresh_q;
		ol_diff = ol_hot ? 11'(fb_mag - thresh_q) : 11'(thresh_q - fb_mag);
		frac_add = 23'(ol_diff) * 23'd10;
		// A remainder left by the other direction would shorten the first step
		frac_base = (ol_up_q == ol_hot) ? frac_q : 23'h0;
		heat_den = 23'(heat_q) * 23'(HEAT_UNITS_PER_S);
		cool_den = 23'(cool_q) * 23'(HEAT_UNITS_PER_S);
		trip_now = !ol_off && (acc_q != 11'h0) && (acc_q >= trip_lvl);
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			acc_q <= 11'h0;
			frac_q <= 23'h0;
			ol_up_q <= 1'b0;
		end else if (ol_off) begin
			acc_q <= 11'h0;
			frac_q <= 23'h0;
			ol_up_q <= 1'b0;
		end else if (ms_tick && ol_hot) begin
			ol_up_q <= 1'b1;
			if (heat_q == 8'h0) begin
				acc_q <= trip_lvl;
				frac_q <= 23'h0;
			end else if (frac_base + frac_add >= heat_den) begin
				frac_q <= frac_base + frac_add - heat_den;
				acc_q <= (acc_q == 11'(ACC_FULL)) ? acc_q : acc_q + 11'h1;
			end else begin
				frac_q <= frac_base + frac_add;
			end
		end else if (ms_tick && ol_cold) begin
			ol_up_q <= 1'b0;
			if (cool_q == 8'h0) begin
				acc_q <= 11'h0;
				frac_q <= 23'h0;
			end else if (frac_base + frac_add >= cool_den) begin
				frac_q <= frac_base + frac_add - cool_den;
				acc_q <= (acc_q == 11'h0) ? acc_q : acc_q - 11'h1;
			end else begin
				frac_q <= frac_base + frac_add;
			end
		end
	end

	// Trip latch: a new trip in the reset cycle wins
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			trip_q <= 1'b0;
		end else if (trip_now) begin
			trip_q <= 1'b1;
		end else if (trip_reset) begin
			trip_q <= 1'b0;
		end
	end
	assign overload_trip = trip_q;

	// Autotune sequencer
	assign tune_done = (tune_q == TUNE_RUN) && ms_tick && (tune_ms_q == 8'(TUNE_TIME_MS - 1));
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tune_q <= TUNE_IDLE;
			tune_ms_q <= 8'h0;
		end else begin
			case (tune_q)
				TUNE_IDLE: begin
					tune_ms_q <= 8'h0;
					if (tune_req_q && en_q) begin
						tune_q <= TUNE_RUN;
					end
				end
				TUNE_RUN: begin
					if (tune_done) begin
						tune_q <= TUNE_OPEN;
						tune_ms_q <= 8'h0;
					end else if (ms_tick) begin
						tune_ms_q <= tune_ms_q + 8'h1;
					end
				end
				TUNE_OPEN: begin
					if (ms_tick && tune_ms_q == 8'(READY_OPEN_TIME_MS - 1)) begin
						tune_q <= TUNE_CLEAR;
					end else if (ms_tick) begin
						tune_ms_q <= tune_ms_q + 8'h1;
					end
				end
				TUNE_CLEAR: tune_q <= TUNE_IDLE;
				default: tune_q <= TUNE_IDLE;
			endcase
		end
	end

	// Hardware clear in TUNE_CLEAR beats a software write in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tune_req_q <= 1'b0;
		end else if (tune_q == TUNE_CLEAR) begin
			tune_req_q <= 1'b0;
		end else if (wr_take && avs_req.address == OFS_TUNE) begin
			tune_req_q <= avs_req.writedata[0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			drive_ready <= 1'b0;
			field_off <= 1'b0;
			tune_active <= 1'b0;
		end else begin
			drive_ready <= (tune_q != TUNE_OPEN) && !trip_q;
			field_off <= (tune_q == TUNE_RUN);
			tune_active <= (tune_q != TUNE_IDLE);
		end
	end
endmodule
`default_nettype wire

// ==== sim/dccl_sva.sv ====
// Concurrent checks on the current loop ports.
// Assumes binding into dccl_current_loop, sharing its MS_DIV.
`timescale 1ns/1ps
`default_nettype none
module dccl_sva #(
	parameter int MS_DIV = 10
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic phase_tick,
	input wire logic drive_enable_input,
	input wire logic trip_reset,
	input wire logic [9:0] firing_angle,
	input wire logic overload_trip,
	input wire logic drive_ready,
	input wire logic field_off,
	input wire logic tune_active
);
	logic [15:0] low_cnt_q;
	// Length of the current ready-low stretch; the free ms divider blurs it by one ms
	always_ff @(posedge clk_sys) begin
		if (!reset_n || drive_ready) begin
			low_cnt_q <= '0;
		end else begin
			low_cnt_q <= low_cnt_q + 16'h0001;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	angle_range_a: assert property (firing_angle >= 10'd277 && firing_angle <= 10'd1023)
		else $error("firing angle out of range");
	angle_hold_a: assert property (!phase_tick |=> $stable(firing_angle))
		else $error("firing angle moved without phase tick");
	trip_hold_a: assert property (overload_trip && !trip_reset |=> overload_trip)
		else $error("overload trip dropped without trip reset");
	trip_clear_a: assert property ($fell(overload_trip) |-> $past(trip_reset))
		else $error("overload trip cleared without cause");
	field_tune_a: assert property (field_off |-> tune_active)
		else $error("field off outside tune");
	tune_start_a: assert property ($rose(field_off) |-> $past(drive_enable_input))
		else $error("tune ran without drive enable");
	open_len_a: assert property ($rose(drive_ready) && tune_active |->
		low_cnt_q >= 49 * MS_DIV && low_cnt_q <= 51 * MS_DIV + 4)
		else $error("ready open time wrong");
	tune_clear_a: assert property ($rose(drive_ready) && tune_active |-> ##[0:3] !tune_active)
		else $error("tune did not finish after ready open");
endmodule
bind dccl_current_loop dccl_sva #(.MS_DIV(MS_DIV)) u_sva (.clk_sys(clk_sys), .reset_n(reset_n),
	.phase_tick(phase_tick), .drive_enable_input(drive_enable_input), .trip_reset(trip_reset),
	.firing_angle(firing_angle), .overload_trip(overload_trip), .drive_ready(drive_ready),
	.field_off(field_off), .tune_active(tune_active));
`default_nettype wire

// ==== sim/dccl_far_model.sv ====
// Firing generator and current transformer stand-in.
// Assumes clk_sys; the bench sets the current level that the CTs report.
`timescale 1ns/1ps
`default_nettype none
module dccl_far_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic signed [11:0] ct_level,
	output logic phase_tick,
	output logic signed [11:0] ct_sample
);
	logic [2:0] cnt_q;
	// A short supply period keeps the slew settle time small
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	assign phase_tick = (cnt_q == 3'h7);
	always_ff @(posedge clk_sys) begin
		ct_sample <= ct_level;
	end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench of the current loop over its Avalon-MM slave.
// Assumes MS_DIV of 10 cycles per ms and the far-side model.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dccl_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	dccl_avs_req_t avs_req = '0;
	dccl_avs_rsp_t avs_rsp;
	logic signed [15:0] current_demand = '0;
	logic signed [11:0] ct_level = '0;
	logic signed [11:0] ct_sample;
	logic phase_tick;
	logic drive_enable_input = 1'b0;
	logic trip_reset = 1'b0;
	logic [9:0] firing_angle;
	logic overload_trip, drive_ready, field_off, tune_active;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] rd;
	always #20 clk_sys = ~clk_sys;
	dccl_current_loop #(.MS_DIV(10)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
		.avs_req(avs_req), .avs_rsp(avs_rsp), .current_demand(current_demand),
		.ct_sample(ct_sample), .phase_tick(phase_tick), .drive_enable_input(drive_enable_input),
		.trip_reset(trip_reset), .firing_angle(firing_angle), .overload_trip(overload_trip),
		.drive_ready(drive_ready), .field_off(field_off), .tune_active(tune_active));
	dccl_far_model u_far (.clk_sys(clk_sys), .reset_n(reset_n), .ct_level(ct_level),
		.phase_tick(phase_tick), .ct_sample(ct_sample));
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails = fails + 1;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Request is held until waitrequest is sampled low, then released
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
		// Only the bench timeout ends a wait that never answers
		do begin
			@(posedge clk_sys);
		end while (avs_rsp.waitrequest !== 1'b0);
		rd = avs_rsp.readdata;
		avs_req <= '0;
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, '0);
		chk(nm, rd & 32'hffff, exp & 32'hffff);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic t_regs();
		rdchk("slew", OFS_SLEW, 32'h28);
		rdchk("thr", OFS_THRESHOLD, 32'h2bc);
		rdchk("heat", OFS_HEAT, 32'h1e);
		rdchk("endstop", OFS_ENDSTOP, 32'h0);
		bus(1'b1, OFS_ACCUM, 32'h5);
		rdchk("acc_ro", OFS_ACCUM, 32'h0);
		bus(1'b1, OFS_THRESHOLD, 32'h7d0);
		rdchk("thr_clip", OFS_THRESHOLD, 32'h3e8);
		bus(1'b1, OFS_THRESHOLD, 32'h2bc);
		rdchk("unmapped", 8'hfc, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_fb();
		int ct[4] = '{500, -1000, 1000, -1000};
		int sc[4] = '{1000, 500, 1999, 1999};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, OFS_MAX_SCALE, 32'(sc[i]));
			ct_level <= 12'(ct[i]);
			wait_cyc(4);
			rdchk("fb_norm", OFS_FB_NORM, 32'(ct[i]));
			rdchk("fb_amps", OFS_FB_AMPS, 32'(ct[i] * sc[i] / 1000));
		end
		bus(1'b1, OFS_BURDEN, 32'h1);
		ct_level <= 12'sd800;
		wait_cyc(4);
		rdchk("fb_burden", OFS_FB_NORM, 32'd500);
		bus(1'b1, OFS_BURDEN, 32'h0);
		bus(1'b1, OFS_MAX_SCALE, 32'h3e8);
		ct_level <= '0;
		$display("test feedback done");
	endtask
	task automatic t_angle();
		current_demand <= 16'sd1000;
		// The integral term needs many firing instants to drive the angle to its stop
		wait_cyc(1000);
		rdchk("angle_fwd", OFS_FIRING, 32'd1023);
		chk("angle_pin", {22'h0, firing_angle}, 32'd1023);
		current_demand <= -16'sd1000;
		wait_cyc(2400);
		rdchk("angle_back", OFS_FIRING, 32'd277);
		bus(1'b1, OFS_ENDSTOP, 32'h1);
		wait_cyc(40);
		rdchk("angle_reduced", OFS_FIRING, 32'd330);
		bus(1'b1, OFS_ENDSTOP, 32'h0);
		current_demand <= '0;
		$display("test angle done");
	endtask
	task automatic t_tune();
		int n;
		int lo;
		logic [7:0] ofs[4] = '{OFS_GAIN_DI, OFS_GAIN_CP, OFS_GAIN_CI, OFS_MOTOR_K};
		logic [7:0] val[4] = '{TUNED_GAIN_DI, TUNED_GAIN_CP, TUNED_GAIN_CI, TUNED_MOTOR_K};
		n = 0;
		bus(1'b1, OFS_TUNE, 32'h1);
		drive_enable_input <= 1'b1;
		while (tune_active !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk("tune_run", {31'h0, tune_active}, 32'h1);
		chk("field_off", {31'h0, field_off}, 32'h1);
		n = 0;
		lo = 0;
		while (tune_active !== 1'b0 && n < 4000) begin
			@(posedge clk_sys);
			n++;
			if (drive_ready === 1'b0) lo++;
		end
		chk("ready_open", 32'(lo >= READY_OPEN_TIME_MS * 10 - 5 && lo <= READY_OPEN_TIME_MS * 10 + 5), 32'h1);
		rdchk("tune_req", OFS_TUNE, 32'h0);
		for (int i = 0; i < 4; i++) rdchk("tuned", ofs[i], {24'h0, val[i]});
		drive_enable_input <= 1'b0;
		$display("test tune done");
	endtask
	task automatic t_overload();
		int n;
		n = 0;
		bus(1'b1, OFS_THRESHOLD, 32'd900);
		bus(1'b1, OFS_HEAT, 32'd1);
		bus(1'b1, OFS_COOL, 32'd2);
		ct_level <= 12'sd1000;
		while (overload_trip !== 1'b1 && n < 12000) begin
			@(posedge clk_sys);
			n++;
			if (n == 3000) bus(1'b1, OFS_MAX_SCALE, 32'd100);
		end
		chk("trip_time", 32'(n >= 9500 && n <= 10500), 32'h1);
		rdchk("acc_trip", OFS_ACCUM, 32'd62);
		ct_level <= '0;
		wait_cyc(1500);
		bus(1'b0, OFS_ACCUM, '0);
		chk("cool_mid", 32'(rd != 0), 32'h1);
		wait_cyc(1500);
		rdchk("cool_end", OFS_ACCUM, 32'h0);
		chk("trip_held", {31'h0, overload_trip}, 32'h1);
		trip_reset <= 1'b1;
		@(posedge clk_sys);
		trip_reset <= 1'b0;
		wait_cyc(3);
		chk("trip_clr", {31'h0, overload_trip}, 32'h0);
		bus(1'b1, OFS_HEAT, 32'd0);
		bus(1'b1, OFS_COOL, 32'd0);
		ct_level <= 12'sd1000;
		wait_cyc(1000);
		rdchk("acc_off", OFS_ACCUM, 32'h0);
		chk("trip_off", {31'h0, overload_trip}, 32'h0);
		ct_level <= '0;
		$display("test overload done");
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_regs();
		t_fb();
		t_angle();
		t_tune();
		t_overload();
		final_report();
	end
endmodule
`default_nettype wire
